// File: video_overlay_compositor.sv
// Purpose: mode decode, overlay blend, colour keying and output clipping
// Assumes: one pixel pair (Y0 Y1 U V) per valid cycle, 4:2:2 cosited
// Notes: one cycle from pixel or byte input to registered output
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
module video_overlay_compositor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // mode decode
  output logic video_mode,
  output logic upscale_2x,
  output logic [1:0] input_format,
  output logic mode_reserved,
  // pixel pair input
  input wire logic pixel_valid,
  input wire logic pixel_in_image,
  input wire logic pixel_blank,
  input wire logic [7:0] image_y0,
  input wire logic [7:0] image_y1,
  input wire logic [7:0] image_u,
  input wire logic [7:0] image_v,
  input wire logic [7:0] overlay_y0,
  input wire logic [7:0] overlay_y1,
  input wire logic [7:0] overlay_u,
  input wire logic [7:0] overlay_v,
  // pixel pair output
  output logic out_valid,
  output logic [7:0] out_y0,
  output logic [7:0] out_y1,
  output logic [7:0] out_u,
  output logic [7:0] out_v,
  // raw byte input
  input wire logic raw_valid,
  input wire logic raw_first,
  input wire logic raw_last,
  input wire logic [7:0] raw_byte,
  // raw byte output
  output logic [7:0] data_byte,
  output logic data_valid,
  output logic stream_active,
  output logic message_start_strobe,
  output logic message_end_strobe
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0] output_control;
  logic [15:0] alpha_settings;
  logic [23:0] colour_key_value;
  logic [6:0] key_mask_settings;
  logic [31:0] clip_limits;

  always_ff @(posedge mclk) begin
    if (rst) begin
      output_control <= '0;
      alpha_settings <= '0;
      colour_key_value <= '0;
      key_mask_settings <= '0;
    end else if (reg_write) begin
      unique case (reg_addr)
        compositor_pkg::OUTPUT_CONTROL_OFS:
          output_control <= reg_wdata[8:0];
        compositor_pkg::ALPHA_SETTINGS_OFS:
          alpha_settings <= reg_wdata[15:0];
        compositor_pkg::COLOUR_KEY_VALUE_OFS:
          colour_key_value <= reg_wdata[23:0];
        compositor_pkg::KEY_MASK_SETTINGS_OFS:
          key_mask_settings <= reg_wdata[6:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clip_limits <= compositor_pkg::CLIP_LIMITS_RESET;
    end else if (reg_write &&
                 reg_addr == compositor_pkg::CLIP_LIMITS_OFS) begin
      clip_limits <= reg_wdata;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        compositor_pkg::OUTPUT_CONTROL_OFS:
          reg_rdata <= {23'h000000, output_control};
        compositor_pkg::ALPHA_SETTINGS_OFS:
          reg_rdata <= {16'h0000, alpha_settings};
        compositor_pkg::COLOUR_KEY_VALUE_OFS:
          reg_rdata <= {8'h00, colour_key_value};
        compositor_pkg::KEY_MASK_SETTINGS_OFS:
          reg_rdata <= {25'h0000000, key_mask_settings};
        compositor_pkg::CLIP_LIMITS_OFS:
          reg_rdata <= clip_limits;
        default:
          reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  logic [3:0] mode;
  logic overlay_on, extended_features_on, fine_blend_on, key_on, clip_on;
  logic [7:0] alpha_zero, alpha_one;
  logic [7:0] key_y, key_u, key_v;
  logic [2:0] luma_key_lsb_ignore, chroma_key_lsb_ignore;
  logic [7:0] luma_floor, luma_ceiling, chroma_floor, chroma_ceiling;

  assign mode = output_control[compositor_pkg::MODE_LSB +: 4];
  assign overlay_on = output_control[compositor_pkg::OVERLAY_ON_BIT];
  assign extended_features_on =
    output_control[compositor_pkg::EXTENDED_ON_BIT];
  assign fine_blend_on = output_control[compositor_pkg::FINE_BLEND_BIT];
  assign key_on = output_control[compositor_pkg::KEY_ON_BIT];
  assign clip_on = output_control[compositor_pkg::CLIP_ON_BIT];
  assign alpha_zero = alpha_settings[compositor_pkg::ALPHA_ZERO_LSB +: 8];
  assign alpha_one = alpha_settings[compositor_pkg::ALPHA_ONE_LSB +: 8];
  assign key_y = colour_key_value[compositor_pkg::KEY_Y_LSB +: 8];
  assign key_u = colour_key_value[compositor_pkg::KEY_U_LSB +: 8];
  assign key_v = colour_key_value[compositor_pkg::KEY_V_LSB +: 8];
  assign luma_key_lsb_ignore =
    key_mask_settings[compositor_pkg::LUMA_MASK_LSB +: 3];
  assign chroma_key_lsb_ignore =
    key_mask_settings[compositor_pkg::CHROMA_MASK_LSB +: 3];
  assign luma_floor = clip_limits[compositor_pkg::LUMA_FLOOR_LSB +: 8];
  assign luma_ceiling = clip_limits[compositor_pkg::LUMA_CEILING_LSB +: 8];
  assign chroma_floor = clip_limits[compositor_pkg::CHROMA_FLOOR_LSB +: 8];
  assign chroma_ceiling = clip_limits[compositor_pkg::CHROMA_CEILING_LSB +: 8];

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic streaming_mode, message_mode;

  always_comb begin
    video_mode = 1'b0;
    upscale_2x = 1'b0;
    input_format = 2'b00;
    streaming_mode = 1'b0;
    message_mode = 1'b0;
    mode_reserved = 1'b0;
    unique case (mode)
      compositor_pkg::MODE_CO_SITED_1X, compositor_pkg::MODE_INTERSPERSED_1X,
      compositor_pkg::MODE_420_1X: begin
        video_mode = 1'b1;
        input_format = mode[1:0];
      end
      compositor_pkg::MODE_CO_SITED_2X, compositor_pkg::MODE_INTERSPERSED_2X,
      compositor_pkg::MODE_420_2X: begin
        video_mode = 1'b1;
        upscale_2x = 1'b1;
        input_format = mode[1:0];
      end
      compositor_pkg::MODE_STREAMING: streaming_mode = 1'b1;
      compositor_pkg::MODE_MESSAGE: message_mode = 1'b1;
      // reserved codes: everything idle, no output defined
      default: mode_reserved = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // blend, key and clip helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] blend(input logic [7:0] img,
                                       input logic [7:0] ov,
                                       input logic [7:0] a);
    logic signed [8:0] d;
    logic signed [16:0] p;
    logic signed [9:0] s;
    d = $signed({1'b0, ov}) - $signed({1'b0, img});
    p = $signed({1'b0, a[6:0]}) * d;
    s = $signed(p[16:7]) + $signed({2'b00, img});
    return s[7:0];
  endfunction

  // ignored low bits clamp at four
  function automatic logic [7:0] keep_bits(input logic [2:0] n);
    logic [2:0] m;
    m = (n > compositor_pkg::MAX_KEY_MASK) ? compositor_pkg::MAX_KEY_MASK : n;
    return 8'hFF << m;
  endfunction

  function automatic logic [7:0] clip(input logic [7:0] v,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
    if (v <= lo) begin
      return lo;
    end else if (v >= hi) begin
      return hi;
    end else begin
      return v;
    end
  endfunction

  // ----------------------------------------------------------------
  // overlay compositing
  // ----------------------------------------------------------------
  logic merge_on, fine_on, keying_on;
  logic [7:0] luma_keep, chroma_keep;
  logic chroma_match, key_hit0, key_hit1;
  logic [7:0] alpha0, alpha1, use_alpha0, use_alpha1;

  assign merge_on = video_mode && overlay_on;
  assign fine_on = extended_features_on && fine_blend_on;
  assign keying_on = extended_features_on && key_on;
  assign luma_keep = keep_bits(luma_key_lsb_ignore);
  assign chroma_keep = keep_bits(chroma_key_lsb_ignore);
  assign chroma_match = (((overlay_u ^ key_u) & chroma_keep) == 8'h00) &&
                        (((overlay_v ^ key_v) & chroma_keep) == 8'h00);
  assign key_hit0 = keying_on && chroma_match &&
                    (((overlay_y0 ^ key_y) & luma_keep) == 8'h00);
  assign key_hit1 = keying_on && chroma_match &&
                    (((overlay_y1 ^ key_y) & luma_keep) == 8'h00);
  assign alpha0 = overlay_u[0] ? alpha_one : alpha_zero;
  assign alpha1 = overlay_v[0] ? alpha_one : alpha_zero;
  // coarse steps keep the top three blend bits only
  assign use_alpha0 = fine_on ? alpha0 : {alpha0[7:5], 5'h00};
  assign use_alpha1 = fine_on ? alpha1 : {alpha1[7:5], 5'h00};

  function automatic logic [7:0] mix(input logic [7:0] img,
                                     input logic [7:0] ov,
                                     input logic [7:0] a,
                                     input logic merge,
                                     input logic hit);
    if (!merge || hit) begin
      return img;
    end else if (a[7]) begin
      return ov;
    end else begin
      return blend(img, ov, a);
    end
  endfunction

  logic [7:0] mix_y0, mix_y1, mix_u, mix_v;

  // first-sample alpha and key govern both chroma bytes
  assign mix_y0 = mix(image_y0, overlay_y0, use_alpha0, merge_on, key_hit0);
  assign mix_u =
    mix(image_u, overlay_u, use_alpha0, merge_on, key_hit0);
  assign mix_v =
    mix(image_v, overlay_v, use_alpha0, merge_on, key_hit0);
  assign mix_y1 = mix(image_y1, overlay_y1, use_alpha1, merge_on, key_hit1);

  // ----------------------------------------------------------------
  // clipping, last stage
  // ----------------------------------------------------------------
  logic clip_here;
  logic [7:0] y_lo, y_hi, c_lo, c_hi;

  assign clip_here = pixel_in_image && !pixel_blank;
  assign y_lo = clip_on ? luma_floor : compositor_pkg::FIXED_CLIP_FLOOR;
  assign y_hi = clip_on ? luma_ceiling : compositor_pkg::FIXED_CLIP_CEILING;
  assign c_lo = clip_on ? chroma_floor : compositor_pkg::FIXED_CLIP_FLOOR;
  assign c_hi = clip_on ? chroma_ceiling : compositor_pkg::FIXED_CLIP_CEILING;

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_y0 <= 8'h00;
      out_y1 <= 8'h00;
      out_u <= 8'h00;
      out_v <= 8'h00;
    end else begin
      out_valid <= pixel_valid && video_mode;
      if (pixel_valid && video_mode) begin
        out_y0 <= clip_here ? clip(mix_y0, y_lo, y_hi) : mix_y0;
        out_y1 <= clip_here ? clip(mix_y1, y_lo, y_hi) : mix_y1;
        out_u <= clip_here ? clip(mix_u, c_lo, c_hi) : mix_u;
        out_v <= clip_here ? clip(mix_v, c_lo, c_hi) : mix_v;
      end
    end
  end

  // ----------------------------------------------------------------
  // raw data transfer
  // ----------------------------------------------------------------
  logic raw_take;

  assign raw_take = raw_valid && (streaming_mode || message_mode);

  always_ff @(posedge mclk) begin
    if (rst) begin
      data_byte <= 8'h00;
      data_valid <= 1'b0;
      stream_active <= 1'b0;
      message_start_strobe <= 1'b0;
      message_end_strobe <= 1'b0;
    end else begin
      data_valid <= raw_take;
      if (raw_take) begin
        data_byte <= raw_byte;
      end
      stream_active <= streaming_mode;
      message_start_strobe <= raw_take && message_mode && raw_first;
      message_end_strobe <= raw_take && message_mode && raw_last;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence msg_byte_in;
    message_mode && raw_valid && raw_first;
  endsequence

  sequence msg_byte_out;
    data_valid && message_start_strobe && !stream_active;
  endsequence

  refresh_decode_a: assert property (
    (mode <= 4'h2) |-> video_mode && !upscale_2x && input_format == mode[1:0])
    else $error("refresh mode decode wrong");
  upscale_decode_a: assert property (
    (mode >= 4'h4 && mode <= 4'h6) |-> video_mode && upscale_2x &&
      input_format == mode[1:0])
    else $error("upscale mode decode wrong");
  stream_byte_a: assert property (
    streaming_mode && raw_valid |=> data_valid && stream_active &&
      data_byte == $past(raw_byte) && !message_start_strobe)
    else $error("streamed byte not forwarded");
  message_start_a: assert property (
    msg_byte_in |=> msg_byte_out)
    else $error("message start strobe missing");
  overlay_off_a: assert property (
    pixel_valid && video_mode && !overlay_on && !pixel_in_image |=>
      out_valid && out_y1 == $past(image_y1) && out_u == $past(image_u))
    else $error("overlay merged while disabled");
  full_overlay_a: assert property (
    pixel_valid && merge_on && !keying_on && !pixel_in_image &&
      alpha0[7] |=> out_y0 == $past(overlay_y0) &&
      out_v == $past(overlay_v))
    else $error("full overlay not output");
  key_clear_a: assert property (
    pixel_valid && merge_on && key_hit0 && !pixel_in_image |=>
      out_u == $past(image_u) && out_y0 == $past(image_y0))
    else $error("keyed overlay not transparent");
  fixed_clip_a: assert property (
    pixel_valid && video_mode && clip_here && !clip_on |=>
      out_y0 >= 8'h10 && out_y0 <= 8'hF0 && out_v >= 8'h10 && out_v <= 8'hF0)
    else $error("fixed clip range broken");
  prog_clip_a: assert property (
    pixel_valid && video_mode && clip_here && clip_on &&
      mix_y1 <= luma_floor |=> out_y1 == $past(luma_floor))
    else $error("luma floor not applied");
  reset_limits_a: assert property (
    $past(rst) |-> clip_limits == 32'hF010EB10)
    else $error("clip limits wrong after reset");

endmodule

// File: compositor_pkg.sv
// Purpose: shared constants of the video overlay compositor
// Assumes: byte addressed register port, one aligned word per register
// Notes: field positions are bit indices inside each register word
package compositor_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OUTPUT_CONTROL_OFS = 8'h00;
  localparam logic [7:0] ALPHA_SETTINGS_OFS = 8'h04;
  localparam logic [7:0] COLOUR_KEY_VALUE_OFS = 8'h08;
  localparam logic [7:0] KEY_MASK_SETTINGS_OFS = 8'h0C;
  localparam logic [7:0] CLIP_LIMITS_OFS = 8'h10;

  // ----------------------------------------------------------------
  // output_control fields
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int OVERLAY_ON_BIT = 4;
  localparam int EXTENDED_ON_BIT = 5;
  localparam int FINE_BLEND_BIT = 6;
  localparam int KEY_ON_BIT = 7;
  localparam int CLIP_ON_BIT = 8;
  localparam int CONTROL_WIDTH = 9;

  // ----------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_CO_SITED_1X = 4'h0;
  localparam logic [3:0] MODE_INTERSPERSED_1X = 4'h1;
  localparam logic [3:0] MODE_420_1X = 4'h2;
  localparam logic [3:0] MODE_CO_SITED_2X = 4'h4;
  localparam logic [3:0] MODE_INTERSPERSED_2X = 4'h5;
  localparam logic [3:0] MODE_420_2X = 4'h6;
  localparam logic [3:0] MODE_STREAMING = 4'h8;
  localparam logic [3:0] MODE_MESSAGE = 4'h9;

  // ----------------------------------------------------------------
  // other field positions
  // ----------------------------------------------------------------
  localparam int ALPHA_ZERO_LSB = 0;
  localparam int ALPHA_ONE_LSB = 8;
  localparam int KEY_Y_LSB = 0;
  localparam int KEY_U_LSB = 8;
  localparam int KEY_V_LSB = 16;
  localparam int LUMA_MASK_LSB = 0;
  localparam int CHROMA_MASK_LSB = 4;
  localparam int LUMA_FLOOR_LSB = 0;
  localparam int LUMA_CEILING_LSB = 8;
  localparam int CHROMA_FLOOR_LSB = 16;
  localparam int CHROMA_CEILING_LSB = 24;

  // ----------------------------------------------------------------
  // reset values and fixed limits
  // ----------------------------------------------------------------
  localparam logic [31:0] CLIP_LIMITS_RESET = 32'hF010EB10;
  localparam logic [7:0] FIXED_CLIP_FLOOR = 8'h10;
  localparam logic [7:0] FIXED_CLIP_CEILING = 8'hF0;
  localparam logic [2:0] MAX_KEY_MASK = 3'h4;

endpackage

// File: display_sink.sv
// Purpose: display end that latches each composited pixel pair
// Assumes: out_valid pulses once per accepted pair
// Notes: keeps only the newest pair; a display cannot stall the stream
module display_sink (
  // clock
  input wire logic mclk,
  // pixel pair from the compositor
  input wire logic pair_valid,
  input wire logic [7:0] y0,
  input wire logic [7:0] y1,
  input wire logic [7:0] u,
  input wire logic [7:0] v,
  // captured pair
  output logic [31:0] last_pair
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // capture
  // ---------------------------------------------------------------
  initial last_pair = 32'h0;
  always @(posedge mclk) begin
    if (pair_valid) begin
      last_pair <= {y0, y1, u, v};
    end
  end
endmodule

// File: testbench.sv
// Purpose: self-checking bench for the video overlay compositor
// Assumes: one-cycle latency on every path, as handed over
// Notes: expected blended pixels come from the bench's own blend model; key and clip cases use fixed values
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [7:0] CTL = compositor_pkg::OUTPUT_CONTROL_OFS;
  localparam logic [7:0] AL = compositor_pkg::ALPHA_SETTINGS_OFS;
  localparam logic [7:0] KEY = compositor_pkg::COLOUR_KEY_VALUE_OFS;
  localparam logic [7:0] MSK = compositor_pkg::KEY_MASK_SETTINGS_OFS;
  localparam logic [7:0] CLP = compositor_pkg::CLIP_LIMITS_OFS;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic video_mode, upscale_2x, mode_reserved;
  logic [1:0] input_format;
  logic pixel_valid = 1'b0;
  logic pixel_in_image = 1'b1;
  logic pixel_blank = 1'b0;
  logic [31:0] img = 32'h0;
  logic [31:0] ov = 32'h0;
  logic out_valid, data_valid, stream_active;
  logic [7:0] out_y0, out_y1, out_u, out_v, data_byte;
  logic raw_valid = 1'b0;
  logic raw_first = 1'b0;
  logic raw_last = 1'b0;
  logic [7:0] raw_byte = 8'h00;
  logic message_start_strobe, message_end_strobe;
  logic [31:0] last_pair;
  int error_cnt = 0;
  int compares = 0;

  video_overlay_compositor video_overlay_compositor_i (
    .mclk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .video_mode, .upscale_2x, .input_format, .mode_reserved,
    .pixel_valid, .pixel_in_image, .pixel_blank,
    .image_y0(img[31:24]), .image_y1(img[23:16]),
    .image_u(img[15:8]), .image_v(img[7:0]),
    .overlay_y0(ov[31:24]), .overlay_y1(ov[23:16]),
    .overlay_u(ov[15:8]), .overlay_v(ov[7:0]),
    .out_valid, .out_y0, .out_y1, .out_u, .out_v,
    .raw_valid, .raw_first, .raw_last, .raw_byte,
    .data_byte, .data_valid, .stream_active,
    .message_start_strobe, .message_end_strobe
  );
  display_sink display_sink_i (
    .mclk, .pair_valid(out_valid), .y0(out_y0), .y1(out_y1),
    .u(out_u), .v(out_v), .last_pair
  );
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // floor shift, as the hardware does, so negative steps round down
  function automatic logic [7:0] mix(logic [7:0] i, logic [7:0] o,
                                     logic [7:0] a);
    int p;
    p = int'(a[6:0]) * (int'(o) - int'(i));
    return a[7] ? o : 8'(int'(i) + (p >>> 7));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic pix(input logic [31:0] i, input logic [31:0] o,
                     input logic ii, input logic bl, input logic [31:0] e);
    @(posedge mclk);
    img <= i;
    ov <= o;
    pixel_in_image <= ii;
    pixel_blank <= bl;
    pixel_valid <= 1'b1;
    @(posedge mclk);
    pixel_valid <= 1'b0;
    #1 check({31'h0, out_valid}, 32'h1);
    @(posedge mclk);
    #1 check(last_pair, e);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rd(CLP, d);
    check(d, {8'd240, 8'd16, 8'd235, 8'd16});
    rd(8'h14, d);
    check(d, 32'h0);
    wr(KEY, 32'hFF605040);
    rd(KEY, d);
    check(d, 32'h00605040);
  endtask
  task automatic t_modes();
    logic [3:0] m;
    logic [4:0] e;
    for (int k = 0; k < 16; k++) begin
      m = 4'(k);
      e[4] = (k < 7) && (k != 3);
      e[3] = (k > 3) && (k < 7);
      e[2:1] = e[4] ? m[1:0] : 2'h0;
      e[0] = (k == 3) || (k == 7) || (k > 9);
      wr(CTL, {28'h0, m});
      #1 check({27'h0, video_mode, upscale_2x, input_format,
        mode_reserved}, {27'h0, e});
    end
  endtask
  task automatic t_raw();
    logic [3:0] m;
    for (int k = 0; k < 3; k++) begin
      m = k == 0 ? 4'h8 : (k == 1 ? 4'h9 : 4'h0);
      wr(CTL, {28'h0, m});
      @(posedge mclk);
      raw_valid <= 1'b1;
      raw_first <= 1'b1;
      raw_last <= 1'b1;
      raw_byte <= 8'h5A + 8'(k);
      @(posedge mclk);
      raw_valid <= 1'b0;
      #1 check({28'h0, stream_active, data_valid, message_start_strobe,
        message_end_strobe},
        {28'h0, k == 0, k < 2, k == 1, k == 1});
      if (k < 2) check({24'h0, data_byte}, {24'h0, 8'h5A + 8'(k)});
    end
  endtask
  task automatic t_blend();
    wr(CLP, 32'hFF00FF00);
    wr(AL, 32'h905F);
    wr(CTL, 32'h170);
    pix(32'h20208080, 32'hA0A06140, 1'b1, 1'b0, {mix(8'h20, 8'hA0, 8'h90),
      mix(8'h20, 8'hA0, 8'h5F), 8'h61, 8'h40});
    // outside the image area, full overlay still wins
    pix(32'h20208080, 32'hA0A06140, 1'b0, 1'b0, {8'hA0,
      mix(8'h20, 8'hA0, 8'h5F), 8'h61, 8'h40});
    // coarse steps drop the low alpha bits
    wr(CTL, 32'h130);
    pix(32'h20208080, 32'hA0A06040, 1'b1, 1'b0, {mix(8'h20, 8'hA0, 8'h40),
      mix(8'h20, 8'hA0, 8'h40), mix(8'h80, 8'h60, 8'h40),
      mix(8'h80, 8'h40, 8'h40)});
    wr(CTL, 32'h160);
    pix(32'h20208080, 32'hA0A06040, 1'b1, 1'b0, 32'h20208080);
  endtask
  task automatic t_key();
    wr(AL, 32'h8080);
    wr(KEY, 32'h605040);
    wr(MSK, 32'h24);
    wr(CTL, 32'h1B0);
    pix(32'h30303030, 32'h4F505262, 1'b1, 1'b0, 32'h30503030);
    pix(32'h30303030, 32'h4F505262, 1'b0, 1'b0, 32'h30503030);
    wr(MSK, 32'h23);
    pix(32'h30303030, 32'h4F505262, 1'b1, 1'b0, 32'h4F505262);
    wr(MSK, 32'h24);
    wr(CTL, 32'h130);
    pix(32'h30303030, 32'h4F505262, 1'b1, 1'b0, 32'h4F505262);
  endtask
  task automatic t_clip();
    wr(CTL, 32'h000);
    pix(32'h05FA05F5, 32'h0, 1'b1, 1'b0, 32'h10F010F0);
    pix(32'h05FA05F5, 32'h0, 1'b1, 1'b1, 32'h05FA05F5);
    pix(32'h05FA05F5, 32'h0, 1'b0, 1'b0, 32'h05FA05F5);
    wr(CLP, 32'hF010EB10);
    wr(CTL, 32'h100);
    pix(32'h05ECF511, 32'h0, 1'b1, 1'b0, 32'h10EBF011);
    pix(32'hEC05F511, 32'h0, 1'b1, 1'b0, 32'hEB10F011);
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_raw();
    t_blend();
    t_key();
    t_clip();
    print_verdict();
  end
  // hang guard, far beyond the roughly 140 cycles the run needs
  initial begin
    #5000000;
    error_cnt++;
    print_verdict();
  end
endmodule
